/* verilog/ovsb_bank.v */
// Functional notes
// R1 - add trim, saturated to 250 mV, to target
// R2 - target never above ceiling, ceiling max 3300
// R3 - margin high source uses upper margin setpoint
// R4 - margin low source uses lower margin setpoint
// R5 - slew target at rate times 100 uV/us, except a zero rate, which slews at 100 uV/us
// R6 - rate and slope take effect on commit
// R7 - target never below floor register, except where the floor is above the ceiling
// R8 - every setpoint per page, 16-bit, read/write
// R9 - slope lowers regulated output 10 uV/A, max 1600
// R10 - select plus trim, clamp, then slew
// R11 - source field 00 nominal, 01 low, 10 high
`timescale 1ns/100ps
`include "ovsb_regs.vh"

module ovsb_bank #(
	parameter PAGES = 2,
	parameter PW    = 1,
	parameter IW    = 8
) (
	// clock and reset
	input  wire                  i_clk,
	input  wire                  i_rst_n,
	// command port from the bus engine
	input  wire [PW-1:0]         i_page,
	input  wire [7:0]            i_cmd,
	input  wire                  i_wr_en,
	input  wire [15:0]           i_wr_data,
	input  wire                  i_rd_en,
	output wire [15:0]           o_rd_data,
	output wire                  o_rd_valid,
	output wire                  o_cmd_unsup,
	// per-page regulation inputs
	input  wire [PAGES*2-1:0]    i_vout_src,
	input  wire [PAGES*16-1:0]   i_vout_cmd,
	input  wire [PAGES*IW-1:0]   i_iout_a,
	// per-page regulation outputs
	output wire [PAGES*16-1:0]   o_target_mv,
	output wire [PAGES*16-1:0]   o_reg_mv,
	output wire [PAGES-1:0]      o_commit_pending
);
	// per-page register storage
	reg  [15:0] trim_q      [0:PAGES-1];
	reg  [15:0] ceiling_q   [0:PAGES-1];
	reg  [15:0] margin_hi_q [0:PAGES-1];
	reg  [15:0] margin_lo_q [0:PAGES-1];
	reg  [15:0] slew_q      [0:PAGES-1];
	reg  [15:0] slope_q     [0:PAGES-1];
	reg  [15:0] floor_q     [0:PAGES-1];
	// values in use by the regulation path
	reg  [15:0] slew_use_q  [0:PAGES-1];
	reg  [15:0] slope_use_q [0:PAGES-1];

	reg  [15:0] rd_data_q;
	reg         rd_valid_q;
	reg         unsup_q;
	reg  [15:0] rd_data_d;
	reg         hit_d;

	wire        page_ok;
	wire        tick;
	integer     k;

	// unit conversions on the regulation path
	localparam [15:0]    SLOPE_LIM = `OVSB_SLOPE_LIM;
	localparam [IW+10:0] DROP_DIV  = {{(IW+7){1'b0}}, 4'ha};
	localparam [16:0]    MV_DIV    = 17'h0000a;

	assign page_ok = ({{(32-PW){1'b0}}, i_page} < PAGES);

	// command decode
	always @* begin
		rd_data_d = 16'h0000;
		hit_d     = 1'b1;
		case (i_cmd)
		`OVSB_CMD_TRIM: begin
			rd_data_d = trim_q[i_page];
		end
		`OVSB_CMD_CEILING: begin
			rd_data_d = ceiling_q[i_page];
		end
		`OVSB_CMD_MARGIN_HI: begin
			rd_data_d = margin_hi_q[i_page];
		end
		`OVSB_CMD_MARGIN_LO: begin
			rd_data_d = margin_lo_q[i_page];
		end
		`OVSB_CMD_SLEW: begin
			rd_data_d = slew_q[i_page];
		end
		`OVSB_CMD_SLOPE: begin
			rd_data_d = slope_q[i_page];
		end
		`OVSB_CMD_FLOOR: begin
			rd_data_d = floor_q[i_page];
		end
		`OVSB_CMD_COMMIT: begin
			rd_data_d = 16'h0000;
		end
		default: begin
			hit_d = 1'b0;
		end
		endcase
		if (!page_ok) begin
			rd_data_d = 16'h0000;
			hit_d     = 1'b0;
		end
	end

	// register writes and commit
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			for (k = 0; k < PAGES; k = k + 1) begin
				trim_q[k]      <= `OVSB_RST_TRIM;
				ceiling_q[k]   <= `OVSB_RST_CEILING;
				margin_hi_q[k] <= `OVSB_RST_MARGIN_HI;
				margin_lo_q[k] <= `OVSB_RST_MARGIN_LO;
				slew_q[k]      <= `OVSB_RST_SLEW;
				slope_q[k]     <= `OVSB_RST_SLOPE;
				floor_q[k]     <= `OVSB_RST_FLOOR;
				slew_use_q[k]  <= `OVSB_RST_SLEW;
				slope_use_q[k] <= `OVSB_RST_SLOPE;
			end
		end else if (i_wr_en && page_ok) begin
			case (i_cmd)
			`OVSB_CMD_TRIM: begin
				trim_q[i_page] <= i_wr_data; // R8
			end
			`OVSB_CMD_CEILING: begin
				ceiling_q[i_page] <= i_wr_data; // R8
			end
			`OVSB_CMD_MARGIN_HI: begin
				margin_hi_q[i_page] <= i_wr_data; // R8
			end
			`OVSB_CMD_MARGIN_LO: begin
				margin_lo_q[i_page] <= i_wr_data; // R8
			end
			`OVSB_CMD_SLEW: begin
				slew_q[i_page] <= i_wr_data; // R8
			end
			`OVSB_CMD_SLOPE: begin
				slope_q[i_page] <= i_wr_data; // R8
			end
			`OVSB_CMD_FLOOR: begin
				floor_q[i_page] <= i_wr_data; // R8
			end
			`OVSB_CMD_COMMIT: begin
				for (k = 0; k < PAGES; k = k + 1) begin
					slew_use_q[k]  <= slew_q[k]; // R6
					slope_use_q[k] <= slope_q[k]; // R6
				end
			end
			default: begin
			end
			endcase
		end
	end

	// read answer, one cycle after the request
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			rd_data_q  <= 16'h0000;
			rd_valid_q <= 1'b0;
			unsup_q    <= 1'b0;
		end else begin
			rd_valid_q <= i_rd_en;
			unsup_q    <= (i_rd_en | i_wr_en) & ~hit_d;
			if (i_rd_en) begin
				rd_data_q <= rd_data_d; // R8
			end
		end
	end

	assign o_rd_data   = rd_data_q;
	assign o_rd_valid  = rd_valid_q;
	assign o_cmd_unsup = unsup_q;

	// shared microsecond step enable
	ovsb_tick #(
		.CYC (`OVSB_SLEW_TICK_CYC)
	) u_tick (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.o_tick  (tick)
	);

	// per-page target path
	genvar p;
	generate
		for (p = 0; p < PAGES; p = p + 1) begin : g_page
			wire [1:0]         src;
			reg  [15:0]        sel;
			wire signed [15:0] trim_raw;
			reg  signed [15:0] trim_sat;
			wire signed [17:0] sum;
			wire [15:0]        ceil_eff;
			reg  [15:0]        floored;
			wire [15:0]        tgt;
			wire [16:0]        tgt_x10;
			wire [16:0]        pos;
			wire [10:0]        slope_eff;
			wire [IW+10:0]     drop_prod;
			wire [IW+10:0]     drop_div;
			wire [16:0]        drop;
			wire [16:0]        drooped;
			wire [15:0]        floor_eff;
			wire [16:0]        floor_x10;
			wire [16:0]        reg_x10;
			wire [16:0]        reg_div;
			reg  [15:0]        tgt_q;
			reg  [15:0]        reg_mv_q;

			assign src = i_vout_src[p*2 +: 2];
			// output source, the unused code falls back to nominal
			always @* begin
				case (src)
				`OVSB_SRC_NOMINAL: begin
					sel = i_vout_cmd[p*16 +: 16]; // R11
				end
				`OVSB_SRC_MARGIN_LO: begin
					sel = margin_lo_q[p]; // R4 R11
				end
				`OVSB_SRC_MARGIN_HI: begin
					sel = margin_hi_q[p]; // R3 R11
				end
				default: begin
					sel = i_vout_cmd[p*16 +: 16]; // R11
				end
				endcase
			end

			// trim is stored as written and saturated on use
			assign trim_raw = trim_q[p];
			always @* begin
				if (trim_raw > $signed(`OVSB_TRIM_POS)) begin
					trim_sat = `OVSB_TRIM_POS; // R1
				end else if (trim_raw < $signed(`OVSB_TRIM_NEG)) begin
					trim_sat = `OVSB_TRIM_NEG; // R1
				end else begin
					trim_sat = trim_raw; // R1
				end
			end
			assign sum = $signed({2'b00, sel}) + $signed({{2{trim_sat[15]}}, trim_sat}); // R1 R10

			assign ceil_eff = (ceiling_q[p] > `OVSB_CEILING_LIM) ? `OVSB_CEILING_LIM : ceiling_q[p]; // R2
			// floor first, so the ceiling wins when the two cross
			always @* begin
				if (sum[17]) begin
					floored = floor_q[p]; // R7 R10
				end else if (sum[16]) begin
					floored = 16'hffff; // R10
				end else if (sum[15:0] < floor_q[p]) begin
					floored = floor_q[p]; // R7 R10
				end else begin
					floored = sum[15:0]; // R10
				end
			end
			assign tgt = (floored > ceil_eff) ? ceil_eff : floored; // R2 R10

			always @(posedge i_clk) begin
				if (!i_rst_n) begin
					tgt_q <= 16'h0000;
				end else begin
					tgt_q <= tgt;
				end
			end

			// ten units of 100 uV per mV, the clamped target fits 14 bits
			assign tgt_x10 = {tgt_q[13:0], 3'b000} + {tgt_q, 1'b0}; // R5

			ovsb_slew u_slew (
				.i_clk    (i_clk),
				.i_rst_n  (i_rst_n),
				.i_tick   (tick),
				.i_target (tgt_x10),
				.i_rate   (slew_use_q[p]), // R5 R6
				.o_pos    (pos)
			);

			// slope in 10 uV/A, drop in 100 uV units
			assign slope_eff = (slope_use_q[p] > SLOPE_LIM) ? SLOPE_LIM[10:0] : slope_use_q[p][10:0]; // R9
			assign drop_prod = slope_eff * i_iout_a[p*IW +: IW]; // R9
			assign drop_div  = drop_prod / DROP_DIV; // R9
			assign drop      = drop_div[16:0]; // R9
			assign drooped   = (pos > drop) ? pos - drop : 17'h00000; // R9
			// a floor above the ceiling gives way to it here as well
			assign floor_eff = (floor_q[p] > ceil_eff) ? ceil_eff : floor_q[p]; // R2 R7
			assign floor_x10 = {floor_eff[13:0], 3'b000} + {floor_eff, 1'b0};
			assign reg_x10   = (drooped < floor_x10) ? floor_x10 : drooped; // R7
			assign reg_div   = reg_x10 / MV_DIV;

			always @(posedge i_clk) begin
				if (!i_rst_n) begin
					reg_mv_q <= 16'h0000;
				end else begin
					reg_mv_q <= reg_div[15:0];
				end
			end

			assign o_target_mv[p*16 +: 16] = tgt_q;
			assign o_reg_mv[p*16 +: 16]    = reg_mv_q;
			assign o_commit_pending[p]     = (slew_q[p] != slew_use_q[p]) | (slope_q[p] != slope_use_q[p]); // R6
		end
	endgenerate
endmodule

/* verilog/ovsb_regs.vh */
`ifndef OVSB_REGS_VH
`define OVSB_REGS_VH

// command codes, one paged 16-bit word each, except the commit code, which stores nothing and copies every page
`define OVSB_CMD_TRIM        8'h22
`define OVSB_CMD_CEILING     8'h24
`define OVSB_CMD_MARGIN_HI   8'h25
`define OVSB_CMD_MARGIN_LO   8'h26
`define OVSB_CMD_SLEW        8'h27
`define OVSB_CMD_SLOPE       8'h28
`define OVSB_CMD_FLOOR       8'h2b
`define OVSB_CMD_COMMIT      8'he7

// reset values
`define OVSB_RST_TRIM        16'h0000
`define OVSB_RST_CEILING     16'h08fc
`define OVSB_RST_MARGIN_HI   16'h0640
`define OVSB_RST_MARGIN_LO   16'h00fa
`define OVSB_RST_SLEW        16'h0064
`define OVSB_RST_SLOPE       16'h0000
`define OVSB_RST_FLOOR       16'h0000

// limits
`define OVSB_TRIM_POS        16'h00fa
`define OVSB_TRIM_NEG        16'hff06
`define OVSB_CEILING_LIM     16'h0ce4
`define OVSB_SLOPE_LIM       16'h0640

// output source field
`define OVSB_SRC_NOMINAL     2'b00
`define OVSB_SRC_MARGIN_LO   2'b01
`define OVSB_SRC_MARGIN_HI   2'b10

// timing: slew rate is counted per microsecond
`define OVSB_CLK_PERIOD_NS   8
`define OVSB_SLEW_TICK_NS    1000
`define OVSB_SLEW_TICK_CYC   (`OVSB_SLEW_TICK_NS / `OVSB_CLK_PERIOD_NS)

`endif

/* verilog/ovsb_tick.v */
`timescale 1ns/100ps
`include "ovsb_regs.vh"

module ovsb_tick #(
	parameter CYC = `OVSB_SLEW_TICK_CYC
) (
	// clock and reset
	input  wire i_clk,
	input  wire i_rst_n,
	// one-cycle enable every CYC cycles
	output wire o_tick
);
	reg [15:0] cnt_q;

	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			cnt_q <= 16'h0000;
		end else if (cnt_q == CYC[15:0] - 16'h0001) begin
			cnt_q <= 16'h0000;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	assign o_tick = (cnt_q == CYC[15:0] - 16'h0001);
endmodule

/* verilog/ovsb_slew.v */
`timescale 1ns/100ps

module ovsb_slew (
	// clock and reset
	input  wire        i_clk,
	input  wire        i_rst_n,
	// step enable and settings, positions in 100 uV units
	input  wire        i_tick,
	input  wire [16:0] i_target,
	input  wire [15:0] i_rate,
	// slewed position
	output wire [16:0] o_pos
);
	reg  [16:0] pos_q;
	wire [16:0] step;
	wire [16:0] gap_up;
	wire [16:0] gap_dn;

	// a zero rate would stall the output, so it moves by one unit
	assign step   = (i_rate == 16'h0000) ? 17'h00001 : {1'b0, i_rate};
	assign gap_up = i_target - pos_q;
	assign gap_dn = pos_q - i_target;

	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			pos_q <= 17'h00000;
		end else if (i_tick) begin
			if (i_target > pos_q) begin
				pos_q <= (gap_up > step) ? pos_q + step : i_target; // R5
			end else if (i_target < pos_q) begin
				pos_q <= (gap_dn > step) ? pos_q - step : i_target; // R5
			end
		end
	end

	assign o_pos = pos_q;
endmodule

/* test/ovsb_asserts.sv */
`timescale 1ns/100ps
`include "ovsb_regs.vh"
module ovsb_asserts #(
	parameter PAGES = 2,
	parameter PW    = 1,
	parameter IW    = 8
) (
	// clock, reset and command port
	input logic                i_clk, i_rst_n, i_wr_en, i_rd_en, o_rd_valid, o_cmd_unsup,
	input logic [PW-1:0]       i_page,
	input logic [7:0]          i_cmd,
	input logic [15:0]         i_wr_data, o_rd_data,
	// regulation side
	input logic [PAGES*2-1:0]  i_vout_src,
	input logic [PAGES*16-1:0] i_vout_cmd, o_target_mv, o_reg_mv,
	input logic [PAGES*IW-1:0] i_iout_a,
	input logic [PAGES-1:0]    o_commit_pending
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	rd_answer_a: assert property (i_rd_en |=> o_rd_valid) else $error("read not answered");
	rd_quiet_a: assert property (!i_rd_en |=> !o_rd_valid) else $error("stray read valid");
	rd_hold_a: assert property (!i_rd_en |=> $stable(o_rd_data)) else $error("read data moved");
	unsup_flag_a: assert property ((i_wr_en || i_rd_en) && i_cmd == 8'h23 |=> o_cmd_unsup)
		else $error("unknown code not flagged");
	unsup_zero_a: assert property (i_rd_en && i_cmd == 8'h23 |=> o_rd_data == 16'h0000)
		else $error("unknown code read not zero");
	ceil_limit_a: assert property (o_target_mv[15:0] <= `OVSB_CEILING_LIM) else $error("target above limit");
	slew_pend_a: assert property (i_wr_en && i_cmd == `OVSB_CMD_SLEW && i_page == 0 |=> o_commit_pending[0])
		else $error("pending not set");
	commit_clear_a: assert property (i_wr_en && i_cmd == `OVSB_CMD_COMMIT |=> o_commit_pending == 0)
		else $error("pending not cleared");
endmodule
bind ovsb_bank ovsb_asserts #(.PAGES(PAGES), .PW(PW), .IW(IW)) chk_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_valid(o_rd_valid), .o_cmd_unsup(o_cmd_unsup), .i_page(i_page),
	.i_cmd(i_cmd), .i_wr_data(i_wr_data), .o_rd_data(o_rd_data), .i_vout_src(i_vout_src), .i_vout_cmd(i_vout_cmd),
	.o_target_mv(o_target_mv), .o_reg_mv(o_reg_mv), .i_iout_a(i_iout_a), .o_commit_pending(o_commit_pending));

/* test/ovsb_host.sv */
`timescale 1ns/100ps
module ovsb_host (
	input  logic        i_clk,
	output logic [0:0]  o_page = 0,
	output logic [7:0]  o_cmd = 0,
	output logic        o_wr_en = 0,
	output logic        o_rd_en = 0,
	output logic [15:0] o_wr_data = 0
);
	// whole 16-bit words, one request held for one edge
	task automatic wr(input logic [0:0] p, input logic [7:0] c, input logic [15:0] d);
		@(posedge i_clk);
		o_page <= p;
		o_cmd <= c;
		o_wr_data <= d;
		o_wr_en <= 1'b1;
		@(posedge i_clk);
		o_wr_en <= 1'b0;
		o_wr_data <= ~d;
	endtask
	task automatic rd(input logic [0:0] p, input logic [7:0] c);
		@(posedge i_clk);
		o_page <= p;
		o_cmd <= c;
		o_rd_en <= 1'b1;
		@(posedge i_clk);
		o_rd_en <= 1'b0;
	endtask
endmodule

/* test/testbench.sv */
`timescale 1ns/100ps
`include "ovsb_regs.vh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module testbench;
	logic        i_clk = 0, i_rst_n = 0, wr_en, rd_en;
	logic [3:0]  i_vout_src = 0;
	logic [31:0] i_vout_cmd = {16'd900, 16'd900};
	logic [15:0] i_iout_a = 0, wr_data, rv, tmp, exp_v;
	logic [0:0]  page;
	logic [7:0]  cmd;
	wire  [15:0] o_rd_data;
	wire         o_rd_valid, o_cmd_unsup;
	wire  [31:0] o_target_mv, o_reg_mv;
	wire  [1:0]  o_commit_pending;
	logic [15:0] exp_q[$];
	int          err_count = 0, checked = 0, cyc = 0;
	logic [7:0]  cmds[7] = '{8'h22, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h2b};
	logic [15:0] rsts[7] = '{16'h0000, 16'h08fc, 16'h0640, 16'h00fa, 16'h0064, 16'h0000, 16'h0000};
	always #4 i_clk = ~i_clk;
	ovsb_host host_u (.i_clk(i_clk), .o_page(page), .o_cmd(cmd), .o_wr_en(wr_en), .o_rd_en(rd_en),
		.o_wr_data(wr_data));
	ovsb_bank #(.PAGES(2), .PW(1), .IW(8)) dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_page(page), .i_cmd(cmd),
		.i_wr_en(wr_en), .i_wr_data(wr_data), .i_rd_en(rd_en), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
		.o_cmd_unsup(o_cmd_unsup), .i_vout_src(i_vout_src), .i_vout_cmd(i_vout_cmd), .i_iout_a(i_iout_a),
		.o_target_mv(o_target_mv), .o_reg_mv(o_reg_mv), .o_commit_pending(o_commit_pending));
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic rd(input logic [0:0] p, input logic [7:0] c, input logic [15:0] e);
		exp_q.push_back(e);
		host_u.rd(p, c);
	endtask
	task automatic tgt(input logic [1:0] s, input logic [15:0] v, input logic [15:0] e);
		@(posedge i_clk);
		i_vout_src[1:0] <= s;
		i_vout_cmd[15:0] <= v;
		repeat (3) @(posedge i_clk);
		`CHK(o_target_mv[15:0], e)
	endtask
	task automatic slew(input logic [15:0] d);
		@(posedge i_clk);
		tmp = o_reg_mv[15:0];
		repeat (125) @(posedge i_clk);
		`CHK(o_reg_mv[15:0] - tmp, d)
	endtask
	task automatic drp(input logic [7:0] a, input logic [15:0] e);
		@(posedge i_clk);
		i_iout_a[7:0] <= a;
		repeat (3) @(posedge i_clk);
		`CHK(o_reg_mv[15:0], e)
	endtask
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_count++;
			stop_test();
		end
		if (o_rd_valid === 1'b1) begin
			if (exp_q.size() > 0) begin
				exp_v = exp_q.pop_front();
				`CHK(o_rd_data, exp_v)
			end else
				`CHK(1'b0, 1'b1)
		end
	end
	initial begin
		rv = $urandom(66555);
		repeat (10) @(posedge i_clk);
		i_rst_n <= 1'b1;
		for (int p = 0; p < 2; p++)
			for (int i = 0; i < 7; i++)
				rd(p[0:0], cmds[i], rsts[i]);
		$display("test reset values done");
		for (int i = 0; i < 7; i++) begin
			rv = $urandom;
			host_u.wr(1'b1, cmds[i], rv);
			rd(1'b1, cmds[i], rv);
			rd(1'b0, cmds[i], rsts[i]);
		end
		rd(1'b0, 8'h23, 16'h0000);
		host_u.wr(1'b0, 8'h23, 16'h1234);
		@(negedge i_clk);
		`CHK(o_cmd_unsup, 1'b1)
		$display("test paging done");
		slew(16'd10);
		host_u.wr(1'b0, `OVSB_CMD_SLEW, 16'd200);
		@(negedge i_clk);
		`CHK(o_commit_pending[0], 1'b1)
		slew(16'd10);
		host_u.wr(1'b0, `OVSB_CMD_COMMIT, 16'h0000);
		@(negedge i_clk);
		`CHK(o_commit_pending, 2'b00)
		slew(16'd20);
		repeat (6000) @(posedge i_clk);
		`CHK(o_reg_mv[15:0], 16'd900)
		$display("test slew done");
		host_u.wr(1'b0, `OVSB_CMD_SLOPE, 16'd100);
		drp(8'd50, 16'd900);
		host_u.wr(1'b0, `OVSB_CMD_COMMIT, 16'h0000);
		drp(8'd50, 16'd850);
		host_u.wr(1'b0, `OVSB_CMD_SLOPE, 16'h2000);
		host_u.wr(1'b0, `OVSB_CMD_COMMIT, 16'h0000);
		drp(8'd50, 16'd100);
		$display("test droop done");
		tgt(2'b00, 16'd900, 16'd900);
		tgt(2'b01, 16'd900, 16'd250);
		tgt(2'b10, 16'd900, 16'd1600);
		host_u.wr(1'b0, `OVSB_CMD_TRIM, 16'h0010);
		tgt(2'b00, 16'd900, 16'd916);
		host_u.wr(1'b0, `OVSB_CMD_TRIM, 16'h0400);
		tgt(2'b00, 16'd900, 16'd1150);
		host_u.wr(1'b0, `OVSB_CMD_TRIM, 16'hfc00);
		tgt(2'b00, 16'd900, 16'd650);
		host_u.wr(1'b0, `OVSB_CMD_TRIM, 16'h0000);
		host_u.wr(1'b0, `OVSB_CMD_CEILING, 16'h0300);
		tgt(2'b00, 16'd900, 16'd768);
		host_u.wr(1'b0, `OVSB_CMD_CEILING, 16'h2000);
		tgt(2'b00, 16'd4000, 16'd3300);
		host_u.wr(1'b0, `OVSB_CMD_FLOOR, 16'h03e8);
		tgt(2'b01, 16'd900, 16'd1000);
		$display("test target done");
		repeat (4) @(posedge i_clk);
		stop_test();
	end
endmodule
